// >>> common/run_dwell_pkg.sv
// Constants for the run permit gate and dwell ramp sequencer.
// Assumes a 100 MHz system clock; frequencies in 0.01 Hz, times in 0.1 s ticks.
package run_dwell_pkg;
   // ==========================================================================
   // Clock and tick
   localparam int unsigned CLK_HZ         = 100_000_000;
   localparam int unsigned TICK_MS        = 100;
   localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TICK_MS;
   // ==========================================================================
   // Terminal function and modes
   localparam logic [5:0]  FUNC_RUN_PERMIT = 6'h0d;
   localparam logic        PERMIT_ALWAYS   = 1'h0;
   localparam logic        PERMIT_TERMINAL = 1'h1;
   localparam logic [1:0]  STOP_COAST      = 2'h0;
   localparam logic [1:0]  STOP_QUICK      = 2'h1;
   localparam logic [1:0]  STOP_QUICK_RES  = 2'h2;
   localparam logic [1:0]  CTRL_VF         = 2'h0;
   // ==========================================================================
   // Defaults and limits (freq 0.01 Hz, time 0.1 s)
   localparam logic [15:0] QSTOP_DEF       = 16'h0032;
   localparam logic [15:0] QSTOP_MAX       = 16'h1770;
   localparam logic [15:0] DWELL_FREQ_DEF  = 16'h01f4;
   localparam logic [15:0] ACC_DWELL_MAX   = 16'h0064;
   localparam logic [15:0] DEC_DWELL_MAX   = 16'h0258;
   localparam logic [15:0] TIME_ZERO       = 16'h0000;
   localparam logic [15:0] FREQ_ZERO       = 16'h0000;
   // ==========================================================================
   // Register map
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_TERM_FUNC   = 4'h1;
   localparam logic [3:0]  REG_QSTOP_TIME  = 4'h2;
   localparam logic [3:0]  REG_ACC_DFREQ   = 4'h3;
   localparam logic [3:0]  REG_ACC_DTIME   = 4'h4;
   localparam logic [3:0]  REG_DEC_DFREQ   = 4'h5;
   localparam logic [3:0]  REG_DEC_DTIME   = 4'h6;
   localparam logic [3:0]  REG_TARGET      = 4'h7;
   localparam logic [3:0]  REG_STATUS      = 4'h8;
   localparam logic [3:0]  REG_OUT_FREQ    = 4'h9;
   // CTRL fields
   localparam int unsigned CTRL_PERMIT_SEL = 0;
   localparam int unsigned CTRL_STOP_LO    = 1;
   localparam int unsigned CTRL_MODE_LO    = 3;
   localparam int unsigned CTRL_BRAKE_EXT  = 5;
   localparam logic [15:0] CTRL_RESET      = 16'h0000;
endpackage

// >>> design/tick_gen.sv
// Tick generator: one-cycle pulse every CYCLES enabled clocks.
// Assumes the caller's clock enable gates every state change.
`timescale 1ns/10ps
module tick_gen #(
   parameter int unsigned CYCLES = 10
) (
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   input  wire logic i_ce,
   input  wire logic i_clear,
   output logic      o_tick
);
   localparam int unsigned CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt_r;

   initial begin
      if (CYCLES < 2) $error("tick_gen CYCLES must be at least 2");
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_r <= '0;
      end else if (i_ce) begin
         if (i_clear || cnt_r == CW'(CYCLES - 1)) begin
            cnt_r <= '0;
         end else begin
            cnt_r <= cnt_r + CW'(1);
         end
      end
   end

   assign o_tick = i_ce && !i_clear && (cnt_r == CW'(CYCLES - 1));
endmodule // tick_gen

// >>> design/run_permit_dwell.sv
// Run permit gate and dwell ramp sequencer for a drive's frequency reference.
// Assumes terminal and run inputs come from pins; registers on a plain port.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
module run_permit_dwell #(
   parameter int unsigned N_TERM      = 5,
   parameter int unsigned FW          = 16,
   // Clocks per 0.1 s tick; a bench may shorten it to reach the dwells
   parameter int unsigned TICK_CYCLES = run_dwell_pkg::TICK_CYCLES
) (
   input  wire logic              i_clk,
   input  wire logic              i_arst_n,
   input  wire logic              i_ce,
   input  wire logic [N_TERM-1:0] i_term,
   input  wire logic              i_run,
   input  wire logic [3:0]        i_addr,
   input  wire logic [15:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic [15:0]            o_rdata,
   output logic [FW-1:0]          o_freq,
   output logic                   o_drive_en
);
   typedef enum logic [2:0] {ST_IDLE, ST_ACC, ST_ACC_DWELL, ST_RUN, ST_DEC,
                             ST_DEC_DWELL, ST_QSTOP, ST_LOCK} state_e;

   initial begin
      if (N_TERM < 1 || N_TERM > 8) $error("N_TERM must be 1 to 8");
      if (FW != 16) $error("FW must be 16");
      if (TICK_CYCLES < 2) $error("TICK_CYCLES must be at least 2");
   end

   // ==========================================================================
   // Input synchronisers
   logic [N_TERM:0] s1_r, s2_r, s3_r, stable_r;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_r     <= '0;
         s2_r     <= '0;
         s3_r     <= '0;
         stable_r <= '0;
      end else if (i_ce) begin
         s1_r <= {i_run, i_term};
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int k = 0; k <= N_TERM; k++) begin
            if (s2_r[k] == s3_r[k]) stable_r[k] <= s3_r[k];
         end
      end
   end

   // ==========================================================================
   // Registers
   logic [15:0] ctrl_r, qstop_r, acc_f_r, acc_t_r, dec_f_r, dec_t_r, target_r;
   logic [5:0]  func_r [N_TERM];
   logic [15:0] rdata_r;

   function automatic logic [15:0] clip(input logic [15:0] v, input logic [15:0] mx);
      clip = (v > mx) ? mx : v;
   endfunction

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ctrl_r   <= run_dwell_pkg::CTRL_RESET;
         qstop_r  <= run_dwell_pkg::QSTOP_DEF;
         acc_f_r  <= run_dwell_pkg::DWELL_FREQ_DEF;
         acc_t_r  <= run_dwell_pkg::TIME_ZERO;
         dec_f_r  <= run_dwell_pkg::DWELL_FREQ_DEF;
         dec_t_r  <= run_dwell_pkg::TIME_ZERO;
         target_r <= run_dwell_pkg::FREQ_ZERO;
      end else if (i_ce && i_wr) begin
         unique case (i_addr)
            run_dwell_pkg::REG_CTRL:       ctrl_r   <= i_wdata;
            run_dwell_pkg::REG_QSTOP_TIME: qstop_r  <= clip(i_wdata, run_dwell_pkg::QSTOP_MAX);
            run_dwell_pkg::REG_ACC_DFREQ:  acc_f_r  <= i_wdata;
            run_dwell_pkg::REG_ACC_DTIME:  acc_t_r  <= clip(i_wdata, run_dwell_pkg::ACC_DWELL_MAX);
            run_dwell_pkg::REG_DEC_DFREQ:  dec_f_r  <= i_wdata;
            run_dwell_pkg::REG_DEC_DTIME:  dec_t_r  <= clip(i_wdata, run_dwell_pkg::DEC_DWELL_MAX);
            run_dwell_pkg::REG_TARGET:     target_r <= i_wdata;
            default: ;
         endcase
      end
   end

   // Terminal function codes, one terminal per write; an index of N_TERM or above is dropped
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int k = 0; k < N_TERM; k++) func_r[k] <= '0;
      end else if (i_ce && i_wr && i_addr == run_dwell_pkg::REG_TERM_FUNC) begin
         if ({29'h0, i_wdata[10:8]} < N_TERM) func_r[i_wdata[10:8]] <= i_wdata[5:0];
      end
   end

   // ==========================================================================
   // Permit decode
   logic permit_from_terminal, permit, run_cmd, brake_ext, vf_mode;
   logic [1:0] stop_sel;
   always_comb begin
      permit_from_terminal = 1'b0;
      for (int k = 0; k < N_TERM; k++) begin
         if (func_r[k] == run_dwell_pkg::FUNC_RUN_PERMIT && stable_r[k])
            permit_from_terminal = 1'b1;
      end
   end
   assign permit    = (ctrl_r[run_dwell_pkg::CTRL_PERMIT_SEL] == run_dwell_pkg::PERMIT_ALWAYS)
                      || permit_from_terminal;
   assign run_cmd   = stable_r[N_TERM];
   assign stop_sel  = ctrl_r[run_dwell_pkg::CTRL_STOP_LO +: 2];
   assign brake_ext = ctrl_r[run_dwell_pkg::CTRL_BRAKE_EXT];
   assign vf_mode   = ctrl_r[run_dwell_pkg::CTRL_MODE_LO +: 2] == run_dwell_pkg::CTRL_VF;

   // ==========================================================================
   // Tick and phase timer
   logic tick, phase_new;
   logic [15:0] timer_r;
   tick_gen #(.CYCLES(TICK_CYCLES)) u_tick (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_ce     (i_ce),
      .i_clear  (phase_new),
      .o_tick   (tick)
   );

   // ==========================================================================
   // Sequencer
   state_e      st_r, st_nxt;
   logic [15:0] freq_r, freq_nxt;
   logic        first_acc_r, drive_r;
   logic        dwell_acc_ok, dwell_dec_ok, stop_req;

   // Ramp steps one 0.01 Hz unit per tick; ramp shape belongs to the generator
   assign dwell_acc_ok = vf_mode && first_acc_r && acc_t_r != run_dwell_pkg::TIME_ZERO
                         && acc_f_r != run_dwell_pkg::FREQ_ZERO;
   assign dwell_dec_ok = vf_mode && !brake_ext && dec_t_r != run_dwell_pkg::TIME_ZERO
                         && dec_f_r != run_dwell_pkg::FREQ_ZERO;
   assign stop_req     = !run_cmd;

   always_comb begin
      st_nxt   = st_r;
      freq_nxt = freq_r;
      unique case (st_r)
         ST_IDLE: if (run_cmd && permit) st_nxt = ST_ACC;
         ST_ACC, ST_RUN: begin
            if (stop_req) st_nxt = ST_DEC;
            else if (dwell_acc_ok && st_r == ST_ACC && freq_r >= acc_f_r) begin
               st_nxt   = ST_ACC_DWELL;
               freq_nxt = acc_f_r;
            end else if (tick && freq_r < target_r) freq_nxt = freq_r + 16'h0001;
            else if (tick && freq_r > target_r) freq_nxt = freq_r - 16'h0001;
            else if (freq_r == target_r) st_nxt = ST_RUN;
         end
         ST_ACC_DWELL: begin
            if (stop_req) st_nxt = ST_DEC;
            else if (timer_r >= acc_t_r) st_nxt = ST_ACC;
         end
         ST_DEC: begin
            if (!stop_req && permit) st_nxt = ST_ACC;
            // Dwell only while passing down through the plateau, never by a jump up
            else if (dwell_dec_ok && freq_r == dec_f_r && freq_r != run_dwell_pkg::FREQ_ZERO) begin
               st_nxt   = ST_DEC_DWELL;
               freq_nxt = dec_f_r;
            end else if (freq_r == run_dwell_pkg::FREQ_ZERO) st_nxt = ST_IDLE;
            else if (tick) freq_nxt = freq_r - 16'h0001;
         end
         ST_DEC_DWELL: begin
            if (timer_r >= dec_t_r) st_nxt = ST_DEC;
            if (timer_r >= dec_t_r) freq_nxt = freq_r - 16'h0001;
         end
         ST_QSTOP: begin
            // Quick-stop time is only tested for zero; any nonzero value ramps down one unit per tick
            if (freq_r == run_dwell_pkg::FREQ_ZERO || qstop_r == run_dwell_pkg::TIME_ZERO) begin
               freq_nxt = run_dwell_pkg::FREQ_ZERO;
               st_nxt   = (stop_sel == run_dwell_pkg::STOP_QUICK) ? ST_LOCK : ST_IDLE;
            end else if (tick) freq_nxt = freq_r - 16'h0001;
         end
         ST_LOCK: if (!run_cmd) st_nxt = ST_IDLE;
      endcase
      // Permit loss overrides every running phase
      if (!permit && st_r != ST_IDLE && st_r != ST_LOCK && st_r != ST_QSTOP) begin
         if (stop_sel == run_dwell_pkg::STOP_COAST) begin
            st_nxt   = ST_IDLE;
            freq_nxt = run_dwell_pkg::FREQ_ZERO;
         end else begin
            st_nxt = ST_QSTOP;
         end
      end
   end

   assign phase_new = st_nxt != st_r;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_r   <= ST_IDLE;
         freq_r <= run_dwell_pkg::FREQ_ZERO;
      end else if (i_ce) begin
         st_r   <= st_nxt;
         freq_r <= freq_nxt;
      end
   end

   // Phase timer in 0.1 s ticks, cleared at each phase change
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         timer_r <= '0;
      end else if (i_ce) begin
         if (phase_new) timer_r <= '0;
         else if (tick && timer_r != 16'hffff) timer_r <= timer_r + 16'h0001;
      end
   end

   // First-acceleration flag: armed in idle with run off, spent in accel dwell, run or decel
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         first_acc_r <= 1'b1;
      end else if (i_ce) begin
         if (st_r == ST_IDLE && !run_cmd) first_acc_r <= 1'b1;
         else if (st_r == ST_ACC_DWELL || st_r == ST_DEC || st_r == ST_RUN)
            first_acc_r <= 1'b0;
      end
   end

   // Drive enable drops at once on coast stop
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) drive_r <= 1'b0;
      else if (i_ce) drive_r <= (st_nxt != ST_IDLE) && (st_nxt != ST_LOCK);
   end

   // ==========================================================================
   // Read port
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rdata_r <= '0;
      end else if (i_ce) begin
         rdata_r <= '0;
         if (i_rd) begin
            unique case (i_addr)
               run_dwell_pkg::REG_CTRL:       rdata_r <= ctrl_r;
               run_dwell_pkg::REG_QSTOP_TIME: rdata_r <= qstop_r;
               run_dwell_pkg::REG_ACC_DFREQ:  rdata_r <= acc_f_r;
               run_dwell_pkg::REG_ACC_DTIME:  rdata_r <= acc_t_r;
               run_dwell_pkg::REG_DEC_DFREQ:  rdata_r <= dec_f_r;
               run_dwell_pkg::REG_DEC_DTIME:  rdata_r <= dec_t_r;
               run_dwell_pkg::REG_TARGET:     rdata_r <= target_r;
               run_dwell_pkg::REG_STATUS:
                  rdata_r <= {7'h00, permit, first_acc_r, drive_r, run_cmd, 2'h0, st_r};
               run_dwell_pkg::REG_OUT_FREQ:   rdata_r <= freq_r;
               default: rdata_r <= '0;
            endcase
         end
      end
   end

   assign o_rdata    = rdata_r;
   assign o_freq     = freq_r;
   assign o_drive_en = drive_r;

   // ==========================================================================
   // Assertions
   coast_block_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && (st_r == ST_ACC || st_r == ST_RUN) && !permit
       && stop_sel == run_dwell_pkg::STOP_COAST)
      |=> (!o_drive_en && freq_r == run_dwell_pkg::FREQ_ZERO))
      else $error("coast stop did not block the drive");
   qstop_enter_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (i_ce && (st_r == ST_ACC || st_r == ST_RUN) && !permit
       && stop_sel == run_dwell_pkg::STOP_QUICK)
      |=> st_r == ST_QSTOP)
      else $error("quick stop not entered");
   lock_hold_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (st_r == ST_LOCK && run_cmd) |=> st_r == ST_LOCK)
      else $error("restart without a fresh run command");
   freq_monotone_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (st_r == ST_QSTOP && $past(st_r) == ST_QSTOP) |-> freq_r <= $past(freq_r))
      else $error("quick stop raised the frequency");
   acc_dwell_hold_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (st_r == ST_ACC_DWELL && $past(st_r) == ST_ACC_DWELL) |-> freq_r == acc_f_r)
      else $error("accel dwell frequency not held");
   dec_dwell_hold_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (st_r == ST_DEC_DWELL && $past(st_r) == ST_DEC_DWELL) |-> freq_r == dec_f_r)
      else $error("decel dwell frequency not held");
   dwell_skip_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (st_r != ST_ACC_DWELL && acc_t_r == run_dwell_pkg::TIME_ZERO) |=> st_r != ST_ACC_DWELL)
      else $error("zero-time accel dwell was not skipped");
   brake_no_dwell_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
      (st_r == ST_DEC && brake_ext) |=> st_r != ST_DEC_DWELL)
      else $error("decel dwell under brake control");
   qstop_range_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
      qstop_r <= run_dwell_pkg::QSTOP_MAX)
      else $error("quick stop time out of range");
endmodule // run_permit_dwell

// >>> verification/term_model.sv
// Partner model: multi-function input terminal pins and the motor output stage.
// Assumes one clock; the bench commands pin levels through set_pins.
`timescale 1ns/10ps
module term_model (
   input  wire logic        i_clk,
   input  wire logic        i_drive_en,
   input  wire logic [15:0] i_freq,
   output logic [4:0]       o_term,
   output logic             o_run,
   output logic             o_spinning
);
   // ==========================================================================
   // Pin drivers
   initial begin
      o_term = 5'h00;
      o_run  = 1'b0;
   end
   // Pins change just after an edge so the synchroniser never sees a race
   task automatic set_pins(input logic [4:0] term, input logic run);
      @(posedge i_clk);
      o_term <= term;
      o_run  <= run;
   endtask
   // ==========================================================================
   // Output stage
   // Current flows only while the stage is enabled and a frequency is asked
   assign o_spinning = i_drive_en && (i_freq != 16'h0000);
endmodule // term_model

// >>> verification/tb_top.sv
// Self-checking bench for the run permit gate and dwell sequencer.
// Assumes a 4-clock tick in place of 0.1 s so that ramps and dwells fit the run.
`timescale 1ns/10ps
module tb_top;
   logic        i_clk;
   logic        i_arst_n;
   logic        i_ce;
   logic [4:0]  term;
   logic        run;
   logic [3:0]  i_addr;
   logic [15:0] i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic [15:0] o_rdata;
   logic [15:0] o_freq;
   logic        o_drive_en;
   logic        spinning;
   logic [15:0] d;
   logic [15:0] v;
   int          seed;
   int          error_cnt;
   int          check_count;
   int          cyc;
   // ==========================================================================
   // Instances
   run_permit_dwell #(.N_TERM(5), .FW(16), .TICK_CYCLES(4)) dut (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_term(term), .i_run(run),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_freq(o_freq), .o_drive_en(o_drive_en));
   term_model u_part (
      .i_clk(i_clk), .i_drive_en(o_drive_en), .i_freq(o_freq), .o_term(term),
      .o_run(run), .o_spinning(spinning));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // ==========================================================================
   // Tasks and functions
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] w);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= w;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] r);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd   <= 1'b0;
      #1 r = o_rdata;
   endtask
   // Polls the state field with a bounded count, then compares
   task automatic wait_state(input logic [2:0] exp);
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 0; i < 100; i++) begin
         rd(run_dwell_pkg::REG_STATUS, s);
         if (s[2:0] === exp) break;
      end
      chk({13'h0000, s[2:0]}, {13'h0000, exp}, "state");
   endtask
   function automatic logic [15:0] clip(input logic [15:0] x, input logic [15:0] mx);
      return (x > mx) ? mx : x;
   endfunction
   // ==========================================================================
   // Timeout
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("MISMATCH t=%0t run did not finish", $time);
         end_of_test();
      end
   end
   // ==========================================================================
   // Main sequence
   initial begin
      seed = 32'he4385129;
      i_arst_n = 1'b0;
      i_ce = 1'b1;
      i_addr = 4'h0;
      i_wdata = 16'h0000;
      i_wr = 1'b0;
      i_rd = 1'b0;
      repeat (6) @(posedge i_clk);
      i_arst_n <= 1'b1;
      rd(run_dwell_pkg::REG_CTRL, d);
      chk(d, run_dwell_pkg::CTRL_RESET, "ctrl");
      rd(run_dwell_pkg::REG_QSTOP_TIME, d);
      chk(d, run_dwell_pkg::QSTOP_DEF, "qstop");
      rd(run_dwell_pkg::REG_ACC_DFREQ, d);
      chk(d, run_dwell_pkg::DWELL_FREQ_DEF, "acc freq");
      rd(run_dwell_pkg::REG_ACC_DTIME, d);
      chk(d, run_dwell_pkg::TIME_ZERO, "acc time");
      rd(run_dwell_pkg::REG_DEC_DFREQ, d);
      chk(d, run_dwell_pkg::DWELL_FREQ_DEF, "dec freq");
      rd(run_dwell_pkg::REG_DEC_DTIME, d);
      chk(d, run_dwell_pkg::TIME_ZERO, "dec time");
      rd(run_dwell_pkg::REG_OUT_FREQ, d);
      chk(d, run_dwell_pkg::FREQ_ZERO, "out freq");
      for (int a = 10; a < 16; a++) begin
         rd(4'(a), d);
         chk(d, 16'h0000, "unmapped");
      end
      $display("test defaults done");
      // Limits: the exact decel dwell maximum and one past the accel dwell maximum first, then random values
      for (int i = 0; i < 12; i++) begin
         v = (i == 0) ? run_dwell_pkg::DEC_DWELL_MAX : 16'($random(seed));
         if (i == 1) v = run_dwell_pkg::ACC_DWELL_MAX + 16'h0001;
         wr(run_dwell_pkg::REG_QSTOP_TIME, v);
         wr(run_dwell_pkg::REG_ACC_DTIME, v);
         wr(run_dwell_pkg::REG_DEC_DTIME, v);
         rd(run_dwell_pkg::REG_QSTOP_TIME, d);
         chk(d, clip(v, run_dwell_pkg::QSTOP_MAX), "qstop clip");
         rd(run_dwell_pkg::REG_ACC_DTIME, d);
         chk(d, clip(v, run_dwell_pkg::ACC_DWELL_MAX), "acc clip");
         rd(run_dwell_pkg::REG_DEC_DTIME, d);
         chk(d, clip(v, run_dwell_pkg::DEC_DWELL_MAX), "dec clip");
      end
      $display("test limits done");
      // Permit on terminal 2, coast stop; drive and frequency drop at once on permit loss
      wr(run_dwell_pkg::REG_TERM_FUNC, {5'h00, 3'h2, 2'h0, run_dwell_pkg::FUNC_RUN_PERMIT});
      rd(run_dwell_pkg::REG_TERM_FUNC, d);
      chk(d, 16'h0000, "term func read");
      wr(run_dwell_pkg::REG_QSTOP_TIME, run_dwell_pkg::TIME_ZERO);
      wr(run_dwell_pkg::REG_TARGET, 16'h0040);
      wr(run_dwell_pkg::REG_CTRL, 16'h0001);
      u_part.set_pins(5'h08, 1'b1);
      repeat (12) @(posedge i_clk);
      wait_state(3'h0);
      chk({15'h0000, o_drive_en}, 16'h0000, "drive w/o permit");
      u_part.set_pins(5'h04, 1'b1);
      wait_state(3'h1);
      rd(run_dwell_pkg::REG_STATUS, d);
      chk({15'h0000, d[8]}, 16'h0001, "permit bit");
      chk({15'h0000, o_drive_en}, 16'h0001, "drive on");
      u_part.set_pins(5'h08, 1'b1);
      repeat (8) @(posedge i_clk);
      #1 chk({15'h0000, o_drive_en}, 16'h0000, "coast block");
      chk(o_freq, run_dwell_pkg::FREQ_ZERO, "coast freq");
      chk({15'h0000, spinning}, 16'h0000, "coast spin");
      u_part.set_pins(5'h08, 1'b0);
      wait_state(3'h0);
      $display("test coast done");
      for (int m = 1; m < 3; m++) begin
         wr(run_dwell_pkg::REG_CTRL, 16'((m << 1) | 1));
         // Zero quick-stop time drops at once; a nonzero one ramps down
         wr(run_dwell_pkg::REG_QSTOP_TIME, 16'(m - 1));
         u_part.set_pins(5'h04, 1'b1);
         wait_state(3'h1);
         u_part.set_pins(5'h00, 1'b1);
         repeat (24) @(posedge i_clk);
         #1 chk(o_freq, run_dwell_pkg::FREQ_ZERO, "qstop freq");
         u_part.set_pins(5'h04, 1'b1);
         repeat (12) @(posedge i_clk);
         rd(run_dwell_pkg::REG_STATUS, d);
         chk({13'h0000, d[2:0]}, (m == 2) ? 16'h0001 : 16'h0007, "after permit");
         u_part.set_pins(5'h04, 1'b0);
         wait_state(3'h0);
         u_part.set_pins(5'h04, 1'b1);
         wait_state(3'h1);
         u_part.set_pins(5'h04, 1'b0);
         wait_state(3'h0);
      end
      $display("test quick stop done");
      wr(run_dwell_pkg::REG_CTRL, 16'h0000);
      u_part.set_pins(5'h00, 1'b1);
      wait_state(3'h1);
      chk({15'h0000, o_drive_en}, 16'h0001, "always permit");
      u_part.set_pins(5'h00, 1'b0);
      wait_state(3'h0);
      $display("test always permit done");
      // Dwell at 8 and 4 for 5 ticks each, target 16; second pass under brake control
      wr(run_dwell_pkg::REG_ACC_DFREQ, 16'h0008);
      wr(run_dwell_pkg::REG_ACC_DTIME, 16'h0005);
      wr(run_dwell_pkg::REG_DEC_DFREQ, 16'h0004);
      wr(run_dwell_pkg::REG_DEC_DTIME, 16'h0005);
      wr(run_dwell_pkg::REG_TARGET, 16'h0010);
      for (int b = 0; b < 2; b++) begin
         wr(run_dwell_pkg::REG_CTRL, (b == 1) ? 16'h0020 : 16'h0000);
         u_part.set_pins(5'h00, 1'b1);
         wait_state(3'h2);
         chk(o_freq, 16'h0008, "acc dwell freq");
         wait_state(3'h3);
         chk(o_freq, 16'h0010, "target freq");
         chk({15'h0000, spinning}, 16'h0001, "spinning");
         rd(run_dwell_pkg::REG_STATUS, d);
         chk({15'h0000, d[7]}, 16'h0000, "first acc spent");
         u_part.set_pins(5'h00, 1'b0);
         // 56 clocks in: twelve 4-clock steps from 16 reach the plateau at 4
         repeat (56) @(posedge i_clk);
         rd(run_dwell_pkg::REG_STATUS, d);
         chk({13'h0000, d[2:0]}, (b == 1) ? 16'h0004 : 16'h0005, "dec dwell");
         if (b == 0) chk(o_freq, 16'h0004, "dec dwell freq");
         wait_state(3'h0);
         chk(o_freq, run_dwell_pkg::FREQ_ZERO, "stopped");
      end
      $display("test dwell done");
      end_of_test();
   end
endmodule // tb_top
